// file: logic/data_signal_modulator.sv
// How it works
// - carrier-high select is four bits choosing pin, clocks, PWMs, oscillator or cells.
// - carrier-low has its own four-bit select over the same list, except that code 0000 is its own carrier-low pin.
// - five-bit modulator select maps pin, software bit, PWMs, comparators, cells, serial.
// - modulator codes 10100 to 11111 connect nothing, modulator level stays low.
// - modulator high passes carrier-high, modulator low passes carrier-low.
// - output is each carrier gated by the modulator state that selects it.
// - disabled forces carriers low and modulator to software bit, selects kept.
// - high sync waits for carrier-high to fall before moving to carrier-low.
// - low sync waits for carrier-low to fall before moving to carrier-high.
// - without sync the carrier switches in the same cycle the modulator moves.
// - carrier-high polarity bit inverts the selected carrier-high source.
// - carrier-low polarity bit inverts the selected carrier-low source.
// - output polarity bit inverts the modulated output, idling high.
// - enable bit set mixes signals; cleared, the module drives no output.
// - read-only status bit shows the current modulated output value.
// - mixing keeps running in sleep while its sources keep running.
// - any reset disables module and clears both control registers.
// - unimplemented register bits read zero and ignore writes.
module data_signal_modulator
(
	input  wire logic                           sys_clk,   // system clock, 50 MHz
	input  wire logic                           rst,       // async reset, active high
	input  wire logic [mix_pkg::ADDR_W-1:0]     reg_addr,  // register index
	input  wire logic [mix_pkg::DATA_W-1:0]     reg_wdata, // write data
	input  wire logic                           reg_wr,    // write strobe
	input  wire logic                           reg_rd,    // read strobe
	output logic      [mix_pkg::DATA_W-1:0]     reg_rdata, // read data, cycle after strobe
	input  wire logic                           pin_carrier_high, // routed carrier-high pin
	input  wire logic                           pin_carrier_low,  // routed carrier-low pin
	input  wire logic                           pin_modulator,    // routed modulator pin
	input  wire logic                           fast_internal_oscillator, // async osc
	input  wire logic                           reference_clock_out,      // async ref clock
	input  wire logic [4:0]                     capture_compare_unit, // units 1-5, PWM mode
	input  wire logic [1:0]                     pwm_out,              // PWM6, PWM7
	input  wire logic                           numeric_oscillator_output, // osc output
	input  wire logic [1:0]                     comparator_out,   // comparators 1, 2
	input  wire logic [3:0]                     logic_cell,       // logic cells 1-4
	input  wire logic                           serial_port_dt,   // serial DT
	input  wire logic                           serial_port_txck, // serial TX/CK
	input  wire logic [1:0]                     synchronous_serial_port_sdo, // SDO 1, 2
	output logic                                mod_out,   // modulated output pin level
	output logic                                mod_out_oe // output enable of the pin
);

	// register state
	logic                          module_enable_q;
	logic                          output_polarity_q;
	logic                          software_modulation_bit_q;
	logic                          carrier_high_polarity_q;
	logic                          carrier_high_sync_enable_q;
	logic                          carrier_low_polarity_q;
	logic                          carrier_low_sync_enable_q;
	logic [mix_pkg::MOD_SEL_W-1:0] modulator_select_field_q;
	logic [mix_pkg::CAR_SEL_W-1:0] carrier_high_select_field_q;
	logic [mix_pkg::CAR_SEL_W-1:0] carrier_low_select_field_q;

	// datapath
	logic [mix_pkg::SYNC_W-1:0]       async_raw;
	logic [mix_pkg::SYNC_W-1:0]       async_s;
	logic                             fosc_div_q;
	logic [(2**mix_pkg::CAR_SEL_W)-1:0] carh_src;
	logic [(2**mix_pkg::CAR_SEL_W)-1:0] carl_src;
	logic [(2**mix_pkg::MOD_SEL_W)-1:0] mod_src;
	logic                             carh_raw;
	logic                             carl_raw;
	logic                             mod_raw;
	logic                             carh_lvl;
	logic                             carl_lvl;
	logic                             mod_lvl;
	logic                             mixed;
	mix_pkg::carrier_state_e          state_q;
	mix_pkg::carrier_state_e          state_d;

	// pins and free-running oscillators are not sys_clk timed
	assign async_raw = {comparator_out, reference_clock_out, fast_internal_oscillator,
		pin_modulator, pin_carrier_low, pin_carrier_high};

	// synchronise before any edge or level decision
	sync2 #(.WIDTH(mix_pkg::SYNC_W)) u_sync
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (async_raw),
		.sync_out (async_s)
	);

	// system clock cannot be sampled by itself, so it is stood in by half rate
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			fosc_div_q <= mix_pkg::RST_CTRL_BIT;
		else
			fosc_div_q <= ~fosc_div_q;
	end

	// carrier source vectors, index equals select code
	assign carh_src = {logic_cell, numeric_oscillator_output, pwm_out, capture_compare_unit,
		async_s[4], async_s[3], fosc_div_q, async_s[0]};
	assign carl_src = {logic_cell, numeric_oscillator_output, pwm_out, capture_compare_unit,
		async_s[4], async_s[3], fosc_div_q, async_s[1]};

	// modulator vector; reserved codes see constant low
	assign mod_src = {mix_pkg::MOD_RESERVED_FILL, synchronous_serial_port_sdo,
		serial_port_txck, serial_port_dt, logic_cell, async_s[6:5],
		numeric_oscillator_output, pwm_out, capture_compare_unit,
		software_modulation_bit_q, async_s[2]};

	src_mux #(.SEL_W(mix_pkg::CAR_SEL_W)) u_carh_mux
	(
		.src   (carh_src),
		.sel   (carrier_high_select_field_q),
		.level (carh_raw)
	);

	src_mux #(.SEL_W(mix_pkg::CAR_SEL_W)) u_carl_mux
	(
		.src   (carl_src),
		.sel   (carrier_low_select_field_q),
		.level (carl_raw)
	);

	src_mux #(.SEL_W(mix_pkg::MOD_SEL_W)) u_mod_mux
	(
		.src   (mod_src),
		.sel   (modulator_select_field_q),
		.level (mod_raw)
	);

	// disabled: carriers to ground, modulator to software bit, selects untouched
	always_comb
	begin
		carh_lvl = module_enable_q & (carh_raw ^ carrier_high_polarity_q);
		carl_lvl = module_enable_q & (carl_raw ^ carrier_low_polarity_q);
		mod_lvl  = module_enable_q ? mod_raw : software_modulation_bit_q;
	end

	// carrier switchover, held while a synchronised pulse is still high
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			mix_pkg::car_high:
			begin
				// waiting ends once the high carrier has fallen
				if (!mod_lvl && (!carrier_high_sync_enable_q || !carh_lvl))
					state_d = mix_pkg::car_low;
			end
			mix_pkg::car_low:
			begin
				// waiting ends once the low carrier has fallen
				if (mod_lvl && (!carrier_low_sync_enable_q || !carl_lvl))
					state_d = mix_pkg::car_high;
			end
			default:
				state_d = mix_pkg::car_low;
		endcase
	end

	// each carrier gated by the state chosen by the modulator
	always_comb
	begin
		mixed = (state_d == mix_pkg::car_high) ? carh_lvl : carl_lvl;
	end

	// state register; software bit is low after reset, so low carrier first
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_q <= mix_pkg::car_low;
		else
			state_q <= state_d;
	end

	// no sleep gating: runs on whatever its sources still deliver
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mod_out    <= mix_pkg::RST_CTRL_BIT;
			mod_out_oe <= mix_pkg::RST_CTRL_BIT;
		end
		else
		begin
			mod_out    <= mixed ^ output_polarity_q;
			mod_out_oe <= module_enable_q;
		end
	end

	// modulation_control: only implemented bits are stored
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			module_enable_q           <= mix_pkg::RST_CTRL_BIT;
			output_polarity_q         <= mix_pkg::RST_CTRL_BIT;
			software_modulation_bit_q <= mix_pkg::RST_CTRL_BIT;
		end
		else if (reg_wr && reg_addr == mix_pkg::ADDR_MODULATION_CONTROL)
		begin
			module_enable_q           <= reg_wdata[mix_pkg::BIT_MODULE_ENABLE];
			output_polarity_q         <= reg_wdata[mix_pkg::BIT_OUTPUT_POLARITY];
			software_modulation_bit_q <= reg_wdata[mix_pkg::BIT_SOFTWARE_MOD];
		end
	end

	// carrier_control
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			carrier_high_polarity_q    <= mix_pkg::RST_CTRL_BIT;
			carrier_high_sync_enable_q <= mix_pkg::RST_CTRL_BIT;
			carrier_low_polarity_q     <= mix_pkg::RST_CTRL_BIT;
			carrier_low_sync_enable_q  <= mix_pkg::RST_CTRL_BIT;
		end
		else if (reg_wr && reg_addr == mix_pkg::ADDR_CARRIER_CONTROL)
		begin
			carrier_high_polarity_q    <= reg_wdata[mix_pkg::BIT_CARH_POLARITY];
			carrier_high_sync_enable_q <= reg_wdata[mix_pkg::BIT_CARH_SYNC];
			carrier_low_polarity_q     <= reg_wdata[mix_pkg::BIT_CARL_POLARITY];
			carrier_low_sync_enable_q  <= reg_wdata[mix_pkg::BIT_CARL_SYNC];
		end
	end

	// select fields; a single reset is treated as power-on, so they clear too
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			modulator_select_field_q    <= mix_pkg::RST_MOD_SEL;
			carrier_high_select_field_q <= mix_pkg::RST_CAR_SEL;
			carrier_low_select_field_q  <= mix_pkg::RST_CAR_SEL;
		end
		else if (reg_wr)
		begin
			if (reg_addr == mix_pkg::ADDR_MODULATOR_SOURCE)
				modulator_select_field_q <= reg_wdata[mix_pkg::MOD_SEL_W-1:0];
			else if (reg_addr == mix_pkg::ADDR_HIGH_CARRIER)
				carrier_high_select_field_q <= reg_wdata[mix_pkg::CAR_SEL_W-1:0];
			else if (reg_addr == mix_pkg::ADDR_LOW_CARRIER)
				carrier_low_select_field_q <= reg_wdata[mix_pkg::CAR_SEL_W-1:0];
		end
	end

	// read data stand one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= mix_pkg::RST_RDATA;
		else if (reg_rd)
		begin
			reg_rdata <= mix_pkg::READ_ZERO; // unimplemented bits stay zero
			if (reg_addr == mix_pkg::ADDR_MODULATION_CONTROL)
			begin
				reg_rdata[mix_pkg::BIT_MODULE_ENABLE]   <= module_enable_q;
				reg_rdata[mix_pkg::BIT_OUTPUT_STATUS]   <= mod_out;
				reg_rdata[mix_pkg::BIT_OUTPUT_POLARITY] <= output_polarity_q;
				reg_rdata[mix_pkg::BIT_SOFTWARE_MOD]    <= software_modulation_bit_q;
			end
			else if (reg_addr == mix_pkg::ADDR_CARRIER_CONTROL)
			begin
				reg_rdata[mix_pkg::BIT_CARH_POLARITY] <= carrier_high_polarity_q;
				reg_rdata[mix_pkg::BIT_CARH_SYNC]     <= carrier_high_sync_enable_q;
				reg_rdata[mix_pkg::BIT_CARL_POLARITY] <= carrier_low_polarity_q;
				reg_rdata[mix_pkg::BIT_CARL_SYNC]     <= carrier_low_sync_enable_q;
			end
			else if (reg_addr == mix_pkg::ADDR_MODULATOR_SOURCE)
				reg_rdata[mix_pkg::MOD_SEL_W-1:0] <= modulator_select_field_q;
			else if (reg_addr == mix_pkg::ADDR_HIGH_CARRIER)
				reg_rdata[mix_pkg::CAR_SEL_W-1:0] <= carrier_high_select_field_q;
			else if (reg_addr == mix_pkg::ADDR_LOW_CARRIER)
				reg_rdata[mix_pkg::CAR_SEL_W-1:0] <= carrier_low_select_field_q;
		end
		else
			reg_rdata <= mix_pkg::READ_ZERO;
	end

	// checks on the design's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_disabled_no_drive;
		!module_enable_q |=> !mod_out_oe;
	endproperty
	a_disabled_no_drive: assert property (p_disabled_no_drive)
		else $error("output enabled while module disabled");

	property p_status_read;
		reg_rd && reg_addr == mix_pkg::ADDR_MODULATION_CONTROL
			|=> reg_rdata[mix_pkg::BIT_OUTPUT_STATUS] == $past(mod_out);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status bit differs from output");

	property p_reserved_silent;
		module_enable_q && modulator_select_field_q >= mix_pkg::MOD_SEL_RESERVED_MIN
			|-> !mod_lvl;
	endproperty
	a_reserved_silent: assert property (p_reserved_silent)
		else $error("reserved modulator code drives a level");

	property p_disabled_forcing;
		!module_enable_q |-> !carh_lvl && !carl_lvl && mod_lvl == software_modulation_bit_q;
	endproperty
	a_disabled_forcing: assert property (p_disabled_forcing)
		else $error("disabled sources not forced");

	property p_high_sync_hold;
		state_q == mix_pkg::car_high && carrier_high_sync_enable_q && !mod_lvl && carh_lvl
			|=> state_q == mix_pkg::car_high;
	endproperty
	a_high_sync_hold: assert property (p_high_sync_hold)
		else $error("left high carrier during a pulse");

	property p_low_sync_hold;
		state_q == mix_pkg::car_low && carrier_low_sync_enable_q && mod_lvl && carl_lvl
			|=> state_q == mix_pkg::car_low;
	endproperty
	a_low_sync_hold: assert property (p_low_sync_hold)
		else $error("left low carrier during a pulse");

	property p_nosync_switch;
		state_q == mix_pkg::car_high && !carrier_high_sync_enable_q && !mod_lvl
			|=> state_q == mix_pkg::car_low;
	endproperty
	a_nosync_switch: assert property (p_nosync_switch)
		else $error("unsynchronised switch delayed");

	property p_high_passes;
		module_enable_q && mod_lvl && state_q == mix_pkg::car_high && carh_lvl
			&& !output_polarity_q |=> mod_out;
	endproperty
	a_high_passes: assert property (p_high_passes)
		else $error("high carrier pulse not on output");

	property p_inverted_idle;
		!module_enable_q && output_polarity_q [*2] |=> mod_out && !mod_out_oe;
	endproperty
	a_inverted_idle: assert property (p_inverted_idle)
		else $error("inverted output does not idle high");

	property p_ctrl1_zero_bits;
		reg_rd && reg_addr == mix_pkg::ADDR_CARRIER_CONTROL
			|=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0;
	endproperty
	a_ctrl1_zero_bits: assert property (p_ctrl1_zero_bits)
		else $error("unimplemented bits read nonzero");

endmodule

// file: pkg/dsm_pkg.sv
package mix_pkg;

	// register bus shape
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// register indices on the plain register port
	localparam logic [2:0] ADDR_MODULATION_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_CARRIER_CONTROL    = 3'h1;
	localparam logic [2:0] ADDR_MODULATOR_SOURCE   = 3'h2;
	localparam logic [2:0] ADDR_HIGH_CARRIER       = 3'h3;
	localparam logic [2:0] ADDR_LOW_CARRIER        = 3'h4;

	// modulation_control field positions
	localparam int BIT_MODULE_ENABLE   = 7;
	localparam int BIT_OUTPUT_STATUS   = 5;
	localparam int BIT_OUTPUT_POLARITY = 4;
	localparam int BIT_SOFTWARE_MOD    = 0;

	// carrier_control field positions
	localparam int BIT_CARH_POLARITY = 5;
	localparam int BIT_CARH_SYNC     = 4;
	localparam int BIT_CARL_POLARITY = 1;
	localparam int BIT_CARL_SYNC     = 0;

	// select field widths
	localparam int CAR_SEL_W = 4;
	localparam int MOD_SEL_W = 5;

	// first reserved modulator code, all above it connect nothing
	localparam logic [4:0] MOD_SEL_RESERVED_MIN = 5'h14;
	localparam logic [11:0] MOD_RESERVED_FILL   = 12'h000;

	// reset values
	localparam logic       RST_CTRL_BIT = 1'b0;
	localparam logic [3:0] RST_CAR_SEL  = 4'h0;
	localparam logic [4:0] RST_MOD_SEL  = 5'h0;
	localparam logic [7:0] RST_RDATA    = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// inputs passed through the two-stage synchroniser
	localparam int SYNC_W = 7;

	// which carrier the mixer is passing
	typedef enum logic [1:0]
	{
		car_high = 2'b01,
		car_low  = 2'b10
	} carrier_state_e;

endpackage

// file: logic/sync2.sv
// two-stage level synchroniser, one bit per lane
module sync2
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             sys_clk, // system clock
	input  wire logic             rst,     // async reset, active high
	input  wire logic [WIDTH-1:0] async_in, // level from another timing domain
	output logic      [WIDTH-1:0] sync_out  // level in the sys_clk domain
);

	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// file: logic/src_mux.sv
// picks one source level out of a vector by its select code
module src_mux
#(
	parameter int SEL_W = 4
)
(
	input  wire logic [(2**SEL_W)-1:0] src,   // candidate levels, index equals code
	input  wire logic [SEL_W-1:0]      sel,   // select code
	output logic                       level  // chosen level
);

	// unused codes are tied low in the source vector itself
	always_comb
	begin
		level = src[sel];
	end

endmodule

// file: verification/source_model.sv
// stand-in for the peripherals and routed pins that feed the mixer
module source_model
(
	input  wire logic        sys_clk,  // system clock
	input  wire logic        slow,     // long pulses, so carrier waits really happen
	output logic      [15:0] syn_src,  // units, pwm, osc, cells, serial, sdo
	output logic      [6:0]  asy_src   // pins, fast osc, ref clock, comparators
);
	timeunit 1ns;
	timeprecision 1ps;

	// everything starts low so no input is unknown at time zero
	initial
	begin
		syn_src = 16'h0000;
		asy_src = 7'h00;
	end

	// clocked peripherals move just after the edge, on about one edge in eight when slow
	always @(posedge sys_clk)
		if (!slow || $urandom_range(7) == 0)
			syn_src <= 16'($urandom);

	// pins and free oscillators move between edges, away from the sampling point
	always @(posedge sys_clk)
	begin
		#7;
		if (!slow || $urandom_range(5) == 0)
			asy_src = 7'($urandom);
	end
endmodule

// file: verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk = 1'b0; // system clock
	logic        rst = 1'b1;     // reset, active high
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        mod_out;
	logic        mod_out_oe;
	logic        slow = 1'b0;
	logic [15:0] syn_src;
	logic [6:0]  asy_src;
	int          n_fail = 0;
	int          checks = 0;
	// reference model state and register mirror
	logic [15:0] hv_src, lv_src;
	logic [31:0] mv_src;
	logic [6:0]  h1, h2;
	logic        ch, cl, md, st, e_out, e_oe, en, opol, sw, fd;
	logic [3:0]  c1, hs, ls;
	logic [4:0]  ms;
	logic [7:0]  rv, e_rd, wv;
	logic [3:0]  hv, lv;

	always #10 sys_clk = ~sys_clk;

	data_signal_modulator data_signal_modulator_inst
	(
		.sys_clk                    (sys_clk),
		.rst                        (rst),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_rdata                  (reg_rdata),
		.pin_carrier_high           (asy_src[0]),
		.pin_carrier_low            (asy_src[1]),
		.pin_modulator              (asy_src[2]),
		.fast_internal_oscillator   (asy_src[3]),
		.reference_clock_out        (asy_src[4]),
		.capture_compare_unit       (syn_src[4:0]),
		.pwm_out                    (syn_src[6:5]),
		.numeric_oscillator_output  (syn_src[7]),
		.comparator_out             (asy_src[6:5]),
		.logic_cell                 (syn_src[11:8]),
		.serial_port_dt             (syn_src[12]),
		.serial_port_txck           (syn_src[13]),
		.synchronous_serial_port_sdo(syn_src[15:14]),
		.mod_out                    (mod_out),
		.mod_out_oe                 (mod_out_oe)
	);

	source_model source_model_inst
	(
		.sys_clk(sys_clk),
		.slow   (slow),
		.syn_src(syn_src),
		.asy_src(asy_src)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one strobe cycle then one idle cycle, so no strobe is set twice at one edge
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask

	// reference model: pins lag two edges, the mix is registered one edge later
	always @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			{h1, h2, st, e_out, e_oe, e_rd, fd} = '0;
			{en, opol, sw, c1, ms, hs, ls} = '0;
		end
		else
		begin
			// carrier code 0001 sees the half-rate image of the system clock
			hv_src = {syn_src[11:0], h2[4:3], fd, h2[0]};
			lv_src = {syn_src[11:0], h2[4:3], fd, h2[1]};
			mv_src = {12'h000, syn_src[15:12], syn_src[11:8], h2[6:5], syn_src[7:0], sw, h2[2]};
			ch = en & (hv_src[hs] ^ c1[3]);
			cl = en & (lv_src[ls] ^ c1[1]);
			md = en ? mv_src[ms] : sw;
			if (md && !st)
				st = !(c1[0] && cl);
			else if (!md && st)
				st = c1[2] && ch;
			case (reg_addr)
				mix_pkg::ADDR_MODULATION_CONTROL: rv = {en, 1'b0, e_out, opol, 3'h0, sw};
				mix_pkg::ADDR_CARRIER_CONTROL:    rv = {2'h0, c1[3:2], 2'h0, c1[1:0]};
				mix_pkg::ADDR_MODULATOR_SOURCE:   rv = {3'h0, ms};
				mix_pkg::ADDR_HIGH_CARRIER:       rv = {4'h0, hs};
				mix_pkg::ADDR_LOW_CARRIER:        rv = {4'h0, ls};
				default:                          rv = 8'h00;
			endcase
			e_rd = reg_rd ? rv : 8'h00;
			e_out = (st ? ch : cl) ^ opol;
			e_oe = en;
			if (reg_wr)
				case (reg_addr)
					mix_pkg::ADDR_MODULATION_CONTROL:
						{en, opol, sw} = {reg_wdata[7], reg_wdata[4], reg_wdata[0]};
					mix_pkg::ADDR_CARRIER_CONTROL:    c1 = {reg_wdata[5:4], reg_wdata[1:0]};
					mix_pkg::ADDR_MODULATOR_SOURCE:   ms = reg_wdata[4:0];
					mix_pkg::ADDR_HIGH_CARRIER:       hs = reg_wdata[3:0];
					mix_pkg::ADDR_LOW_CARRIER:        ls = reg_wdata[3:0];
					default:                          rv = 8'h00;
				endcase
			h2 = h1;
			h1 = asy_src;
			fd = ~fd;
		end

	// every result compared on the falling edge, where all outputs have settled
	always @(negedge sys_clk)
		if (!rst)
		begin
			check({7'h00, mod_out}, {7'h00, e_out});
			check({7'h00, mod_out_oe}, {7'h00, e_oe});
			check(reg_rdata, e_rd);
		end

	// hang guard, far beyond the whole sequence
	initial
	begin
		#400000;
		n_fail++;
		wrap_up();
	end

	initial
	begin
		void'($urandom(32'he895));
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// reset values, then all-ones written everywhere including unmapped holes
		for (int a = 0; a < 8; a++)
			bus(1'b0, a[2:0], 8'h00);
		for (int a = 0; a < 8; a++)
		begin
			bus(1'b1, a[2:0], 8'hff);
			bus(1'b0, a[2:0], 8'h00);
		end
		$display("test register map done");
		// disabling must leave every select untouched
		bus(1'b1, mix_pkg::ADDR_MODULATION_CONTROL, 8'h00);
		for (int a = 0; a < 5; a++)
			bus(1'b0, a[2:0], 8'h00);
		$display("test disable keeps selects done");
		// every modulator code and every carrier code, system clock one included
		for (int i = 0; i < 64; i++)
		begin
			slow <= i[0];
			hv = i[3:0];
			lv = 4'(15 - i[3:0]);
			bus(1'b1, mix_pkg::ADDR_MODULATOR_SOURCE, {3'h0, i[4:0]});
			bus(1'b1, mix_pkg::ADDR_HIGH_CARRIER, {4'h0, hv});
			bus(1'b1, mix_pkg::ADDR_LOW_CARRIER, {4'h0, lv});
			bus(1'b1, mix_pkg::ADDR_CARRIER_CONTROL, 8'($urandom) & 8'h33);
			// configuration first, enable last
			for (int k = 0; k < 20; k++)
			begin
				wv = {1'b1, 2'h0, i[5], 3'h0, 1'($urandom)};
				bus(1'b1, mix_pkg::ADDR_MODULATION_CONTROL, wv);
			end
			bus(1'b0, mix_pkg::ADDR_MODULATION_CONTROL, 8'h00);
			if (i % 8 == 7)
				bus(1'b1, mix_pkg::ADDR_MODULATION_CONTROL, {3'h0, i[5], 4'h0});
			$display("test mix config %0d done", i);
		end
		// second reset in mid-run clears everything again
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int a = 0; a < 5; a++)
			bus(1'b0, a[2:0], 8'h00);
		$display("test second reset done");
		wrap_up();
	end
endmodule
